//--- hdl/pvt_pkg.sv
// Overview of operation
// - Each line: two channels, 960 active clocks each, blanking 100 to 240 clocks.
// - Exactly 1080 active lines; vertical blanking 20-69 (60 Hz) or 228-300 (50 Hz).
// - All timing counts derive from the pixel clock, 63 to 78 MHz; sequencing and dimming counts here run on pclk at 25 MHz.
// - Frame rate stays 57-63 Hz or 47-53 Hz by family.
// - With spread spectrum clocking, add blanking clocks above the minimum.
// - Each primary is 8-bit unsigned, MSB first, zero meaning black.
// - Wait 200 ms from valid video to backlight on, and before video stops.
// - Hold the logic supply off at least 1.0 s before reapplying it.
// - No interface signals before logic supply is up; remove them first at power-down.
// - Wait at least 100 ms in the final power-down interval.
// - Interface signals stay at defined levels during blanking, never floating.
// - With the logic supply off, all pixel data lines are driven low.
// - Backlight supply rises over at least 20 ms at first power-up.
// - Hold dimming duty between 5% and 100% for 500 ms after backlight on.
package pvt_pkg;
	// ----------------------------------------------------------------
	// Video timing
	// ----------------------------------------------------------------
	localparam int unsigned H_ACTIVE = 960;
	localparam int unsigned H_BLANK_MIN = 100;
	localparam int unsigned H_BLANK_MAX = 240;
	localparam int unsigned H_BLANK_RST = 140;
	localparam int unsigned V_ACTIVE = 1080;
	localparam int unsigned V_BLANK60_MIN = 20;
	localparam int unsigned V_BLANK60_MAX = 69;
	localparam int unsigned V_BLANK50_MIN = 228;
	localparam int unsigned V_BLANK50_MAX = 300;
	localparam int unsigned V_BLANK_RST = 45;
	// ----------------------------------------------------------------
	// Sequencing times and pclk counts (25 MHz)
	// ----------------------------------------------------------------
	localparam int unsigned PCLK_KHZ = 25000;
	localparam int unsigned T_VID_BL_MS = 200;
	localparam int unsigned T_OFF_HOLD_MS = 1000;
	localparam int unsigned T_FINAL_MS = 100;
	localparam int unsigned T_BL_RISE_MS = 20;
	localparam int unsigned T_DIM_HOLD_MS = 500;
	localparam int unsigned T_SUP_SIG_MS = 1;
	localparam int unsigned CYC_VID_BL = T_VID_BL_MS * PCLK_KHZ;
	localparam int unsigned CYC_OFF_HOLD = T_OFF_HOLD_MS * PCLK_KHZ;
	localparam int unsigned CYC_FINAL = T_FINAL_MS * PCLK_KHZ;
	localparam int unsigned CYC_BL_RISE = T_BL_RISE_MS * PCLK_KHZ;
	localparam int unsigned CYC_DIM_HOLD = T_DIM_HOLD_MS * PCLK_KHZ;
	localparam int unsigned CYC_SUP_SIG = T_SUP_SIG_MS * PCLK_KHZ;
	// ----------------------------------------------------------------
	// Register map (word aligned)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_HBLANK = 8'h04;
	localparam logic [7:0] REG_VBLANK = 8'h08;
	localparam logic [7:0] REG_DIM = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_COLOR = 8'h14;
	localparam int unsigned CTRL_ON = 0;
	localparam int unsigned CTRL_FAM50 = 1;
	localparam int unsigned CTRL_MAP = 2;
	localparam int unsigned CTRL_AGP = 3;
	localparam logic [7:0] DIM_RST = 8'hFF;
	localparam logic [7:0] DIM_MIN = 8'h0D;
	localparam int unsigned DIM_MIN_NUM = 5;
	typedef enum logic [2:0] {
		PS_OFF = 3'b000,
		PS_LOGIC = 3'b001,
		PS_VIDEO = 3'b010,
		PS_BL = 3'b011,
		PS_RUN = 3'b100,
		PS_VSTOP = 3'b101,
		PS_SIGOFF = 3'b110,
		PS_HOLD = 3'b111
	} pvt_state_t;
	typedef struct packed {
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
	} pvt_pix_t;
	typedef struct packed {
		logic active;
		pvt_pix_t ch0;
		pvt_pix_t ch1;
	} pvt_link_t;
endpackage : pvt_pkg

//--- hdl/pvt_host.sv
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pvt_host
	import pvt_pkg::*;
#(
	parameter int unsigned VID_BL_CYC = CYC_VID_BL,
	parameter int unsigned OFF_HOLD_CYC = CYC_OFF_HOLD,
	parameter int unsigned FINAL_CYC = CYC_FINAL,
	parameter int unsigned BL_RISE_CYC = CYC_BL_RISE,
	parameter int unsigned DIM_HOLD_CYC = CYC_DIM_HOLD,
	parameter int unsigned SUP_SIG_CYC = CYC_SUP_SIG
) (
	input wire logic pclk, // Register clock.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB enable.
	input wire logic pwrite, // APB direction.
	input wire logic [7:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error.
	input wire logic pix_clk, // Pixel clock domain.
	input wire logic pix_rstn, // Pixel domain reset, active low.
	output pvt_link_t link_out, // Both pixel channels and qualifier.
	output logic panel_logic_supply, // Logic supply enable.
	output logic backlight_supply, // Backlight supply enable.
	output logic backlight_soft_start, // Slow ramp request for first rise.
	output logic backlight_on, // Backlight on control.
	output logic backlight_dimming_pwm, // Dimming duty output.
	output logic map_select, // Bit mapping select to the panel.
	output logic auto_test_pattern // No-signal behaviour select.
);
	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [3:0] ctrl_ff;
	logic [7:0] hblank_ff;
	logic [8:0] vblank_ff;
	logic [7:0] dim_ff;
	logic [23:0] color_ff;
	logic bl_started_ff;
	pvt_state_t state_ff;
	pvt_state_t nxt_state;
	logic [31:0] cnt_ff;
	logic [31:0] nxt_cnt;
	logic [31:0] dim_cnt_ff;
	logic [7:0] pwm_ff;
	wire wr_en = psel && penable && pwrite;
	wire hit_ctrl = paddr == REG_CTRL;
	wire hit_hb = paddr == REG_HBLANK;
	wire hit_vb = paddr == REG_VBLANK;
	wire hit_dim = paddr == REG_DIM;
	wire hit_st = paddr == REG_STATUS;
	wire hit_col = paddr == REG_COLOR;
	wire hit_any = hit_ctrl | hit_hb | hit_vb | hit_dim | hit_st | hit_col;
	// The whole word is compared so that large writes clamp rather than wrap.
	wire [31:0] hb_w = pwdata;
	wire [31:0] vb_w = pwdata;
	wire fam50 = ctrl_ff[CTRL_FAM50];
	// Out-of-range blanking writes are clamped so the link timing always stays legal.
	wire [7:0] hb_clamp = (hb_w < 32'(H_BLANK_MIN)) ? 8'(H_BLANK_MIN) :
		(hb_w > 32'(H_BLANK_MAX)) ? 8'(H_BLANK_MAX) : hb_w[7:0];
	wire [8:0] vmin = fam50 ? 9'(V_BLANK50_MIN) : 9'(V_BLANK60_MIN);
	wire [8:0] vmax = fam50 ? 9'(V_BLANK50_MAX) : 9'(V_BLANK60_MAX);
	wire [8:0] vb_clamp = (vb_w < {23'h000000, vmin}) ? vmin :
		(vb_w > {23'h000000, vmax}) ? vmax : vb_w[8:0];
	// During the dimming hold window the duty may not drop below 5 percent.
	wire dim_hold = dim_cnt_ff != 32'h0000_0000;
	wire [7:0] dim_w = pwdata[7:0];
	wire [7:0] dim_clamp = (dim_hold && dim_w < DIM_MIN) ? DIM_MIN : dim_w;
	wire [8:0] vb_now = (vblank_ff < vmin) ? vmin : (vblank_ff > vmax) ? vmax : vblank_ff;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit_any;
	always_comb begin
		prdata = 32'h0000_0000;
		if (hit_ctrl) prdata = {28'h0000000, ctrl_ff};
		if (hit_hb) prdata = {24'h000000, hblank_ff};
		if (hit_vb) prdata = {23'h000000, vblank_ff};
		if (hit_dim) prdata = {24'h000000, dim_ff};
		if (hit_st) prdata = {27'h0000000, bl_started_ff, dim_hold, state_ff};
		if (hit_col) prdata = {8'h00, color_ff};
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= 4'h0;
			hblank_ff <= 8'(H_BLANK_RST);
			vblank_ff <= 9'(V_BLANK_RST);
			dim_ff <= DIM_RST;
			color_ff <= 24'h000000;
		end else if (wr_en) begin
			if (hit_ctrl) ctrl_ff <= pwdata[3:0];
			if (hit_hb) hblank_ff <= hb_clamp;
			if (hit_vb) vblank_ff <= vb_clamp;
			if (hit_dim) dim_ff <= dim_clamp;
			if (hit_col) color_ff <= pwdata[23:0];
		end else if (dim_hold && dim_ff < DIM_MIN) begin
			dim_ff <= DIM_MIN;
		end
	end
	// ----------------------------------------------------------------
	// Power sequencer
	// ----------------------------------------------------------------
	wire on_req = ctrl_ff[CTRL_ON];
	wire cnt_done = cnt_ff == 32'h0000_0000;
	logic vid_en;
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_done ? 32'h0000_0000 : cnt_ff - 32'h0000_0001;
		case (state_ff)
			PS_OFF: begin
				if (on_req && cnt_done) begin
					nxt_state = PS_LOGIC;
					nxt_cnt = SUP_SIG_CYC;
				end
			end
			PS_LOGIC: begin
				if (cnt_done) begin
					nxt_state = PS_VIDEO;
					nxt_cnt = VID_BL_CYC;
				end
			end
			PS_VIDEO: begin
				if (cnt_done) begin
					nxt_state = PS_BL;
					nxt_cnt = bl_started_ff ? 32'h0000_0000 : BL_RISE_CYC;
				end
			end
			PS_BL: begin
				if (cnt_done) nxt_state = PS_RUN;
			end
			PS_RUN: begin
				if (!on_req) begin
					nxt_state = PS_VSTOP;
					nxt_cnt = VID_BL_CYC;
				end
			end
			PS_VSTOP: begin
				if (cnt_done) begin
					nxt_state = PS_SIGOFF;
					nxt_cnt = FINAL_CYC;
				end
			end
			PS_SIGOFF: begin
				if (cnt_done) begin
					nxt_state = PS_HOLD;
					nxt_cnt = OFF_HOLD_CYC;
				end
			end
			PS_HOLD: begin
				if (cnt_done) nxt_state = PS_OFF;
			end
			default: begin
				nxt_state = PS_OFF;
				nxt_cnt = 32'h0000_0000;
			end
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= PS_OFF;
			cnt_ff <= 32'h0000_0000;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
		end
	end
	// Backlight soft start only applies to the very first rise after reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bl_started_ff <= 1'b0;
			dim_cnt_ff <= 32'h0000_0000;
		end else begin
			if (state_ff == PS_RUN) bl_started_ff <= 1'b1;
			if (state_ff == PS_BL && nxt_state == PS_RUN) dim_cnt_ff <= DIM_HOLD_CYC;
			else if (dim_hold) dim_cnt_ff <= dim_cnt_ff - 32'h0000_0001;
		end
	end
	wire logic_up = state_ff != PS_OFF && state_ff != PS_HOLD;
	wire sig_ok = logic_up && state_ff != PS_LOGIC && state_ff != PS_SIGOFF;
	assign vid_en = sig_ok;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			panel_logic_supply <= 1'b0;
			backlight_supply <= 1'b0;
			backlight_soft_start <= 1'b0;
			backlight_on <= 1'b0;
			map_select <= 1'b0;
			auto_test_pattern <= 1'b0;
		end else begin
			panel_logic_supply <= logic_up;
			backlight_supply <= state_ff == PS_BL || state_ff == PS_RUN;
			backlight_soft_start <= state_ff == PS_BL && !bl_started_ff;
			backlight_on <= state_ff == PS_RUN;
			map_select <= sig_ok && ctrl_ff[CTRL_MAP];
			auto_test_pattern <= sig_ok && ctrl_ff[CTRL_AGP];
		end
	end
	// ----------------------------------------------------------------
	// Dimming PWM, 255-step duty on pclk
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_ff <= 8'h00;
			backlight_dimming_pwm <= 1'b0;
		end else begin
			pwm_ff <= (pwm_ff == 8'hFE) ? 8'h00 : pwm_ff + 8'h01;
			backlight_dimming_pwm <= (state_ff == PS_RUN) && (pwm_ff < dim_ff);
		end
	end
	// ----------------------------------------------------------------
	// Crossing to the pixel clock domain
	// ----------------------------------------------------------------
	// Timing words are latched by the generator only while video is disabled or at frame start;
	// the two-flop capture itself samples the registers, which APB may write at any time.
	logic [1:0] en_sync_ff;
	logic [7:0] hb_s1_ff, hb_s2_ff;
	logic [8:0] vb_s1_ff, vb_s2_ff;
	logic [23:0] col_s1_ff, col_s2_ff;
	always_ff @(posedge pix_clk or negedge pix_rstn) begin
		if (!pix_rstn) begin
			en_sync_ff <= 2'b00;
			hb_s1_ff <= 8'(H_BLANK_RST);
			hb_s2_ff <= 8'(H_BLANK_RST);
			vb_s1_ff <= 9'(V_BLANK_RST);
			vb_s2_ff <= 9'(V_BLANK_RST);
			col_s1_ff <= 24'h000000;
			col_s2_ff <= 24'h000000;
		end else begin
			en_sync_ff <= {en_sync_ff[0], vid_en};
			hb_s1_ff <= hblank_ff;
			hb_s2_ff <= hb_s1_ff;
			vb_s1_ff <= vb_now;
			vb_s2_ff <= vb_s1_ff;
			col_s1_ff <= color_ff;
			col_s2_ff <= col_s1_ff;
		end
	end
	// ----------------------------------------------------------------
	// Pixel timing generator, qualifier-only framing
	// ----------------------------------------------------------------
	logic [10:0] hcnt_ff;
	logic [10:0] vcnt_ff;
	logic [7:0] hb_lat_ff;
	logic [8:0] vb_lat_ff;
	wire pix_en = en_sync_ff[1];
	wire [10:0] h_total = 11'(H_ACTIVE) + {3'b000, hb_lat_ff};
	wire [10:0] v_total = 11'(V_ACTIVE) + {2'b00, vb_lat_ff};
	wire h_last = hcnt_ff == h_total - 11'h001;
	wire v_last = vcnt_ff == v_total - 11'h001;
	wire in_act = hcnt_ff < 11'(H_ACTIVE) && vcnt_ff < 11'(V_ACTIVE);
	wire [10:0] shade = hcnt_ff + vcnt_ff;
	wire [7:0] grad = shade[10:3];
	always_ff @(posedge pix_clk or negedge pix_rstn) begin
		if (!pix_rstn) begin
			hcnt_ff <= 11'h000;
			vcnt_ff <= 11'h000;
			hb_lat_ff <= 8'(H_BLANK_RST);
			vb_lat_ff <= 9'(V_BLANK_RST);
			link_out <= '0;
		end else if (!pix_en) begin
			hcnt_ff <= 11'h000;
			vcnt_ff <= 11'h000;
			hb_lat_ff <= hb_s2_ff;
			vb_lat_ff <= vb_s2_ff;
			link_out <= '0;
		end else begin
			hcnt_ff <= h_last ? 11'h000 : hcnt_ff + 11'h001;
			if (h_last) begin
				vcnt_ff <= v_last ? 11'h000 : vcnt_ff + 11'h001;
				if (v_last) begin
					hb_lat_ff <= hb_s2_ff;
					vb_lat_ff <= vb_s2_ff;
				end
			end
			link_out.active <= in_act;
			// Blanking drives defined zeros rather than stale pixel data.
			if (in_act) begin
				// Colour register selects a solid fill; zero gives a gray gradient.
				link_out.ch0 <= (col_s2_ff != 24'h000000) ? col_s2_ff : {grad, grad, grad};
				link_out.ch1 <= (col_s2_ff != 24'h000000) ? col_s2_ff : {grad, grad, grad};
			end else begin
				link_out.ch0 <= '0;
				link_out.ch1 <= '0;
			end
		end
	end
endmodule : pvt_host
`default_nettype wire

//--- testbench/pvt_host_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pvt_host_chk
	import pvt_pkg::*;
#(
	parameter int unsigned VID_BL_CYC = 10,
	parameter int unsigned OFF_HOLD_CYC = 10,
	parameter int unsigned FINAL_CYC = 10,
	parameter int unsigned BL_RISE_CYC = 10,
	parameter int unsigned DIM_HOLD_CYC = 10,
	parameter int unsigned SUP_SIG_CYC = 10
) (
	input wire logic pclk, // Register clock.
	input wire logic presetn, // Register reset.
	input wire logic pix_clk, // Pixel clock.
	input wire logic pix_rstn, // Pixel reset.
	input wire pvt_link_t link_out, // Link word.
	input wire logic panel_logic_supply, // Logic supply.
	input wire logic backlight_supply, // Backlight supply.
	input wire logic backlight_on, // Backlight enable.
	input wire logic backlight_dimming_pwm // Dimming output.
);
	// ----------------------------------------------------------------
	// Interval counters
	// ----------------------------------------------------------------
	// A blank run of twenty shortest lines can only be vertical blanking.
	localparam int unsigned VB_RUN = V_BLANK60_MIN * (H_ACTIVE + H_BLANK_MIN);
	logic [31:0] sup_ff, off_ff, dark_ff, bls_ff, on_ff, low_ff, act_ff, blk_ff;
	logic first_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sup_ff <= '0;
			off_ff <= '1;
			dark_ff <= '0;
			bls_ff <= '0;
			on_ff <= '0;
			low_ff <= '0;
			first_ff <= 1'b1;
		end else begin
			sup_ff <= panel_logic_supply ? sup_ff + 1 : '0;
			off_ff <= (panel_logic_supply) ? '0 : ((off_ff == '1) ? off_ff : off_ff + 1);
			dark_ff <= (backlight_on) ? '0 : ((dark_ff == '1) ? dark_ff : dark_ff + 1);
			bls_ff <= backlight_supply ? bls_ff + 1 : '0;
			on_ff <= backlight_on ? on_ff + 1 : '0;
			low_ff <= (backlight_on && !backlight_dimming_pwm) ? low_ff + 1 : '0;
			if (backlight_on) first_ff <= 1'b0;
		end
	end
	always_ff @(posedge pix_clk or negedge pix_rstn) begin
		if (!pix_rstn) begin
			act_ff <= '0;
			blk_ff <= '1;
		end else begin
			act_ff <= link_out.active ? act_ff + 1 : '0;
			if (!panel_logic_supply) blk_ff <= '1;
			else if (link_out.active) blk_ff <= '0;
			else if (blk_ff != '1) blk_ff <= blk_ff + 1;
		end
	end
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_sig_low;
		@(posedge pix_clk) disable iff (!pix_rstn) !panel_logic_supply |-> link_out == '0;
	endproperty
	a_sig_low: assert property (p_sig_low) else $error("link driven with logic supply off");
	property p_sup_first;
		@(posedge pclk) disable iff (!presetn)
		!panel_logic_supply |-> !backlight_supply && !backlight_on;
	endproperty
	a_sup_first: assert property (p_sup_first) else $error("backlight ahead of logic supply");
	property p_vid_bl;
		@(posedge pclk) disable iff (!presetn)
		$rose(backlight_supply) |-> sup_ff >= SUP_SIG_CYC + VID_BL_CYC - 1;
	endproperty
	a_vid_bl: assert property (p_vid_bl) else $error("backlight too soon after video");
	property p_off_hold;
		@(posedge pclk) disable iff (!presetn)
		$rose(panel_logic_supply) |-> off_ff >= OFF_HOLD_CYC - 1;
	endproperty
	a_off_hold: assert property (p_off_hold) else $error("logic supply reapplied too soon");
	property p_final;
		@(posedge pclk) disable iff (!presetn)
		$fell(panel_logic_supply) |-> dark_ff >= VID_BL_CYC + FINAL_CYC - 1;
	endproperty
	a_final: assert property (p_final) else $error("power-down intervals too short");
	property p_soft;
		@(posedge pclk) disable iff (!presetn)
		$rose(backlight_on) && first_ff |-> bls_ff >= BL_RISE_CYC - 1;
	endproperty
	a_soft: assert property (p_soft) else $error("first backlight rise too short");
	property p_dim;
		@(posedge pclk) disable iff (!presetn)
		backlight_on && on_ff < DIM_HOLD_CYC |-> low_ff < 256;
	endproperty
	a_dim: assert property (p_dim) else $error("dimming duty below floor in hold");
	property p_line;
		@(posedge pix_clk) disable iff (!pix_rstn) $fell(link_out.active) |-> act_ff == H_ACTIVE;
	endproperty
	a_line: assert property (p_line) else $error("active run not one half line");
	property p_hblank;
		@(posedge pix_clk) disable iff (!pix_rstn) $rose(link_out.active) |->
		(blk_ff >= H_BLANK_MIN && blk_ff <= H_BLANK_MAX) || blk_ff >= VB_RUN;
	endproperty
	a_hblank: assert property (p_hblank) else $error("blank run out of range");
	c_bl_on: cover property (@(posedge pclk) disable iff (!presetn) $rose(backlight_on));
	c_sup_off: cover property (@(posedge pclk) disable iff (!presetn) $fell(panel_logic_supply));
	c_line: cover property (@(posedge pix_clk) disable iff (!pix_rstn) $fell(link_out.active));
endmodule : pvt_host_chk
bind pvt_host pvt_host_chk #(
	.VID_BL_CYC(VID_BL_CYC),
	.OFF_HOLD_CYC(OFF_HOLD_CYC),
	.FINAL_CYC(FINAL_CYC),
	.BL_RISE_CYC(BL_RISE_CYC),
	.DIM_HOLD_CYC(DIM_HOLD_CYC),
	.SUP_SIG_CYC(SUP_SIG_CYC)
) i_chk (
	.pclk(pclk),
	.presetn(presetn),
	.pix_clk(pix_clk),
	.pix_rstn(pix_rstn),
	.link_out(link_out),
	.panel_logic_supply(panel_logic_supply),
	.backlight_supply(backlight_supply),
	.backlight_on(backlight_on),
	.backlight_dimming_pwm(backlight_dimming_pwm)
);
`default_nettype wire

//--- testbench/pvt_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module pvt_panel_model
	import pvt_pkg::*;
(
	input wire logic pix_clk, // Link clock.
	input wire logic pix_rstn, // Link reset.
	input wire pvt_link_t link, // Received link word.
	input wire logic panel_logic_supply, // Logic supply.
	input wire logic map_select, // Mapping select.
	input wire logic auto_test_pattern, // No-signal select.
	output var logic [15:0] n_lines, // Lines seen since power-up.
	output var logic [15:0] line_len, // Last active run.
	output var logic [15:0] blank_len, // Last blank run.
	output var pvt_pix_t pix0, // Last first-channel level.
	output var pvt_pix_t pix1, // Last second-channel level.
	output logic jeida, // Mapping in use.
	output logic shows_pattern // Test pattern on screen.
);
	logic [15:0] run_ff, gap_ff;
	logic prev_ff;
	// Position comes from the qualifier alone; syncs are not even an input here.
	always_ff @(posedge pix_clk or negedge pix_rstn) begin
		if (!pix_rstn) begin
			n_lines <= '0;
			line_len <= '0;
			blank_len <= '0;
			run_ff <= '0;
			gap_ff <= '0;
			prev_ff <= 1'b0;
			pix0 <= '0;
			pix1 <= '0;
		end else if (!panel_logic_supply) begin
			n_lines <= '0;
			run_ff <= '0;
			gap_ff <= '0;
			prev_ff <= 1'b0;
		end else if (link.active) begin
			run_ff <= run_ff + 16'h1;
			if (!prev_ff) blank_len <= gap_ff;
			gap_ff <= '0;
			pix0 <= link.ch0;
			pix1 <= link.ch1;
			prev_ff <= 1'b1;
		end else begin
			gap_ff <= gap_ff + 16'h1;
			if (prev_ff) line_len <= run_ff;
			if (prev_ff) n_lines <= n_lines + 16'h1;
			run_ff <= '0;
			prev_ff <= 1'b0;
		end
	end
	assign jeida = map_select;
	assign shows_pattern = panel_logic_supply && auto_test_pattern && n_lines == '0;
endmodule : pvt_panel_model
`default_nettype wire

//--- testbench/test_panel_video_timing_and_power_sequence.sv
`timescale 1ns/1ps
`default_nettype none
module test_panel_video_timing_and_power_sequence
	import pvt_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0, pix_clk = 1'b0, pix_rstn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	pvt_link_t link_out;
	logic panel_logic_supply, backlight_supply, backlight_soft_start, backlight_on;
	logic backlight_dimming_pwm, map_select, auto_test_pattern, jeida, shows_pattern;
	logic [15:0] n_lines, line_len, blank_len;
	pvt_pix_t pix0, pix1;
	int n_fail = 0, n_checks = 0;
	always #20 pclk = ~pclk;
	always #24 pix_clk = ~pix_clk;
	pvt_host #(.VID_BL_CYC(40), .OFF_HOLD_CYC(50), .FINAL_CYC(30), .BL_RISE_CYC(30),
		.DIM_HOLD_CYC(600), .SUP_SIG_CYC(20)) i_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pix_clk(pix_clk),
		.pix_rstn(pix_rstn), .link_out(link_out), .panel_logic_supply(panel_logic_supply),
		.backlight_supply(backlight_supply), .backlight_soft_start(backlight_soft_start),
		.backlight_on(backlight_on), .backlight_dimming_pwm(backlight_dimming_pwm),
		.map_select(map_select), .auto_test_pattern(auto_test_pattern));
	pvt_panel_model i_panel (.pix_clk(pix_clk), .pix_rstn(pix_rstn), .link(link_out),
		.panel_logic_supply(panel_logic_supply), .map_select(map_select),
		.auto_test_pattern(auto_test_pattern), .n_lines(n_lines), .line_len(line_len),
		.blank_len(blank_len), .pix0(pix0), .pix1(pix1), .jeida(jeida),
		.shows_pattern(shows_pattern));
	// ----------------------------------------------------------------
	// Bus and check helpers
	// ----------------------------------------------------------------
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic ck(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: %s got %0h want %0h", $time, what, got, exp);
		end
	endtask : ck
	task automatic wc(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
		apb(1'b1, a, d);
		apb(1'b0, a, 32'h0);
		ck(rd, exp, "register readback");
	endtask : wc
	task automatic wait_st(input pvt_state_t st);
		for (int i = 0; i < 400; i++) begin
			apb(1'b0, REG_STATUS, 32'h0);
			if (rd[2:0] === st) break;
		end
		ck(32'(rd[2:0]), 32'(st), "sequencer state");
	endtask : wait_st
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		apb(1'b0, REG_HBLANK, 32'h0);
		ck(rd, 32'h8C, "hblank reset");
		apb(1'b0, REG_VBLANK, 32'h0);
		ck(rd, 32'h2D, "vblank reset");
		apb(1'b0, REG_DIM, 32'h0);
		ck(rd, 32'hFF, "dim reset");
		wc(REG_HBLANK, 32'h32, 32'h64);
		wc(REG_HBLANK, 32'h12C, 32'hF0);
		wc(REG_VBLANK, 32'hA, 32'h14);
		wc(REG_VBLANK, 32'h50, 32'h45);
		apb(1'b1, REG_CTRL, 32'h2);
		wc(REG_VBLANK, 32'hA, 32'hE4);
		wc(REG_VBLANK, 32'h190, 32'h12C);
		apb(1'b1, REG_CTRL, 32'h0);
		wc(REG_VBLANK, 32'h2D, 32'h2D);
		wc(REG_STATUS, 32'h7, 32'h0);
		apb(1'b1, 8'h18, 32'hFF);
		ck(32'(err), 32'h1, "unmapped write error");
		apb(1'b0, 8'h18, 32'h0);
		ck(32'(err), 32'h1, "unmapped read error");
		ck(rd, 32'h0, "unmapped read data");
	endtask : t_regs
	// Power up with a given blanking, fill colour and panel selects, then measure lines.
	task automatic t_up(input logic [31:0] hb, input logic [31:0] color, input logic [31:0] c);
		apb(1'b1, REG_HBLANK, hb);
		apb(1'b1, REG_COLOR, color);
		apb(1'b1, REG_DIM, 32'h0);
		apb(1'b1, REG_CTRL, c | 32'h1);
		wait_st(PS_RUN);
		@(posedge pclk);
		ck(32'(backlight_on), 32'h1, "backlight on");
		ck(32'(jeida), 32'(c[CTRL_MAP]), "mapping select");
		ck(32'(auto_test_pattern), 32'(c[CTRL_AGP]), "no-signal select");
		for (int i = 0; i < 8000 && n_lines < 16'h3; i++) @(posedge pclk);
		ck(32'(line_len), 32'h3C0, "active clocks per line");
		ck(32'(blank_len), hb, "line blanking");
		ck(32'(pix0), color, "first channel level");
		ck(32'(pix1), color, "second channel level");
	endtask : t_up
	task automatic t_down(input pvt_state_t st);
		apb(1'b1, REG_CTRL, 32'h0);
		wait_st(st);
		@(posedge pclk);
		ck(32'(link_out !== '0), 32'h0, "link idle with supply off");
		ck(32'(panel_logic_supply), 32'h0, "logic supply off");
	endtask : t_down
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : test_done
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		pix_rstn <= 1'b1;
		t_regs();
		// A second reset after the register test must bring HBLANK back to its reset value.
		@(posedge pclk);
		presetn <= 1'b0;
		pix_rstn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		pix_rstn <= 1'b1;
		apb(1'b0, REG_HBLANK, 32'h0);
		ck(rd, 32'h8C, "hblank after second reset");
		t_up(32'h64, 32'h123456, 32'h4);
		// Switching on again mid-hold must not shorten the off time.
		t_down(PS_HOLD);
		t_up(32'hF0, 32'hFF0080, 32'h8);
		t_down(PS_OFF);
		test_done();
	end
	initial begin
		#(40 * 60000);
		n_fail++;
		$display("MISMATCH at %0t: timeout", $time);
		test_done();
	end
endmodule : test_panel_video_timing_and_power_sequence
`default_nettype wire
